// ==== adc_pkg.sv ====
// Constants shared by the converter control logic
package adc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_SC2 = 8'h04;
    localparam logic [7:0] ADDR_SC1 = 8'h08;
    localparam logic [7:0] ADDR_RES_HI = 8'h0C;
    localparam logic [7:0] ADDR_RES_LO = 8'h10;
    localparam logic [7:0] ADDR_CMP_HI = 8'h14;
    localparam logic [7:0] ADDR_CMP_LO = 8'h18;
    localparam logic [7:0] ADDR_PIN_LO = 8'h1C;
    localparam logic [7:0] ADDR_PIN_HI = 8'h20;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Configuration fields
    localparam int CFG_LOW_POWER = 7;
    localparam int CFG_DIV_LO = 5;
    localparam int CFG_LONG_SAMPLE = 4;
    localparam int CFG_MODE_LO = 2;
    localparam int CFG_CLK_LO = 0;
    // Second status and control fields
    localparam int SC2_ACTIVE = 7;
    localparam int SC2_TRIGGER = 6;
    localparam int SC2_CMP_EN = 5;
    localparam int SC2_CMP_GT = 4;
    // First status and control fields
    localparam int SC1_COMPLETE = 7;
    localparam int SC1_IRQ_EN = 6;
    localparam int SC1_CONTINUOUS = 5;
    localparam int SC1_CHANNEL_LO = 0;
    // Resolution and clock source encodings
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_BUS_HALF = 2'h1;
    localparam logic [11:0] FULL_12 = 12'hFFF;
    localparam logic [11:0] FULL_10 = 12'h3FF;
    localparam logic [11:0] FULL_8 = 12'h0FF;
    localparam logic [11:0] ZERO_CODE = 12'h000;
    // Sample length in half conversion clock cycles, rounded up to whole cycles
    localparam int SAMPLE_SHORT_HALVES = 7;
    localparam int SAMPLE_LONG_HALVES = 47;
    localparam logic [5:0] SAMPLE_SHORT = 6'((SAMPLE_SHORT_HALVES + 1) / 2);
    localparam logic [5:0] SAMPLE_LONG = 6'((SAMPLE_LONG_HALVES + 1) / 2);
    localparam logic [5:0] BITS_8 = 6'h08;
    localparam logic [5:0] BITS_10 = 6'h0A;
    localparam logic [5:0] BITS_12 = 6'h0C;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_TRANSFER = 2'b11
    } conv_state_t;
endpackage

// ==== conv_clock_if.sv ====
// Conversion clock request and tick between control and generator
`timescale 1ns/1ps
interface conv_clock_if;
    logic run;
    logic [1:0] source;
    logic [1:0] divide;
    logic alt_level;
    logic tick;
    modport gen(input run, input source, input divide, input alt_level, output tick);
    modport user(output run, output source, output divide, output alt_level, input tick);
endinterface // conv_clock_if

// ==== conv_clock_gen.sv ====
// Conversion clock enable generator: source select and divider
`timescale 1ns/1ps
module conv_clock_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    conv_clock_if.gen ck
);
    logic half;
    logic next_half;
    logic alt_prev;
    logic next_alt_prev;
    logic [2:0] count;
    logic [2:0] next_count;
    logic base_en;
    logic [2:0] limit;

    always_comb begin
        next_half = ck.run ? ~half : 1'b0;
        next_alt_prev = ck.alt_level;
        case (ck.source)
            adc_pkg::SRC_BUS: base_en = 1'b1;
            adc_pkg::SRC_BUS_HALF: base_en = half;
            default: base_en = ck.alt_level & ~alt_prev;
        endcase
        limit = 3'((4'h1 << ck.divide) - 4'h1);
        next_count = count;
        if (!ck.run) begin
            next_count = 3'h0;
        end else if (base_en) begin
            next_count = (count == limit) ? 3'h0 : 3'(count + 3'h1);
        end
        ck.tick = ck.run & base_en & (count == limit);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half <= 1'b0;
            alt_prev <= 1'b0;
            count <= 3'h0;
        end else begin
            half <= next_half;
            alt_prev <= next_alt_prev;
            count <= next_count;
        end
    end
endmodule // conv_clock_gen

// ==== adc_control.sv ====
// Converter control, register file and conversion sequencer
//
// Contract
// - Deepest stop mode aborts and disables converter
// - Registers return to reset after deepest stop
// - Configuration bit 7 selects low power
// - Bits 6:5 divide input clock, 00 undivided
// - Configuration bit 4 selects long sample
// - Sample 3.5 or 23.5 conversion clock cycles; the code rounds up to 4 or 24
// - Bits 3:2 select 8, 10, 12 bits
// - Bits 1:0 select input clock, 00 bus
// - Second register bit 7 shows conversion active
// - Bit 6 selects software or hardware trigger
// - Bit 5 enables compare, bit 4 direction
// - Second register bits 3:2 read zero
// - First register bit 7 completion flag, read-only
// - Bit 6 enables completion interrupt request
// - Bit 5 selects continuous or single conversion
// - Bits 4:0 select the input channel
// - High byte read locks low byte
// - Compare value held in high/low registers
// - Pin control bit disables digital pin functions
// - Out-of-range inputs clamp to full scale or zero
// - Compare failure sets no flag, stores nothing
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module adc_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System and pins
    input wire logic deep_stop,
    input wire logic hw_trigger,
    input wire logic alt_clock,
    // Analog front end
    input wire logic [11:0] analog_code,
    input wire logic above_high,
    input wire logic below_low,
    output logic [4:0] channel_select,
    output logic sampling,
    output logic low_power,
    output logic [15:0] pin_analog,
    output logic conv_irq
);
    conv_clock_if ck ();

    logic trig_meta, trig_sync, trig_prev;
    logic alt_meta, alt_sync;
    logic [7:0] cfg, sc2_ctl, sc1_ctl, cmp_hi, cmp_lo, pin_lo, pin_hi;
    logic [7:0] next_cfg, next_sc2_ctl, next_sc1_ctl, next_cmp_hi, next_cmp_lo;
    logic [7:0] next_pin_lo, next_pin_hi;
    logic complete, next_complete;
    logic lock, next_lock;
    logic [11:0] result, next_result;
    logic [11:0] sample, next_sample;
    logic [5:0] count, next_count;
    adc_pkg::conv_state_t state, next_state;
    logic [31:0] next_prdata;
    logic [7:0] rdata;
    logic mapped, wr, rd_acc, setup, start, hw_edge, sw_start, finish, cmp_ok;
    logic [5:0] sample_len, bits_len;
    logic [11:0] full_scale, clamped, cmp_value, stored;
    logic [12:0] diff;

    // Pin inputs cross into the bus clock domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
            alt_meta <= 1'b0;
            alt_sync <= 1'b0;
        end else begin
            trig_meta <= hw_trigger;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
            alt_meta <= alt_clock;
            alt_sync <= alt_meta;
        end
    end

    // Bus decode; zero wait states, read data sampled in setup
    always_comb begin
        case (paddr)
            adc_pkg::ADDR_CFG, adc_pkg::ADDR_SC2, adc_pkg::ADDR_SC1,
            adc_pkg::ADDR_RES_HI, adc_pkg::ADDR_RES_LO, adc_pkg::ADDR_CMP_HI,
            adc_pkg::ADDR_CMP_LO, adc_pkg::ADDR_PIN_LO, adc_pkg::ADDR_PIN_HI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        setup = psel & ~penable;
        wr = psel & penable & pwrite & mapped;
        rd_acc = psel & penable & ~pwrite & mapped;
        pready = psel & penable;
        pslverr = psel & penable & ~mapped;
    end

    // Read multiplexer
    always_comb begin
        case (paddr)
            adc_pkg::ADDR_CFG: rdata = cfg;
            adc_pkg::ADDR_SC2: rdata = {state != adc_pkg::ST_IDLE, sc2_ctl[6:4], 4'h0};
            adc_pkg::ADDR_SC1: rdata = {complete, sc1_ctl[6:0]};
            adc_pkg::ADDR_RES_HI: rdata = {4'h0, result[11:8]};
            adc_pkg::ADDR_RES_LO: rdata = result[7:0];
            adc_pkg::ADDR_CMP_HI: rdata = cmp_hi;
            adc_pkg::ADDR_CMP_LO: rdata = cmp_lo;
            adc_pkg::ADDR_PIN_LO: rdata = pin_lo;
            adc_pkg::ADDR_PIN_HI: rdata = pin_hi;
            default: rdata = 8'h00;
        endcase
        next_prdata = setup ? {24'h000000, rdata} : prdata;
    end

    // Conversion clock request
    always_comb begin
        ck.run = (state != adc_pkg::ST_IDLE);
        ck.divide = cfg[adc_pkg::CFG_DIV_LO +: 2];
        ck.source = cfg[adc_pkg::CFG_CLK_LO +: 2];
        ck.alt_level = alt_sync;
    end

    conv_clock_gen gen (
        .clk(clk),
        .rst(rst),
        .ck(ck)
    );

    // Sample, resolution, clamp and compare arithmetic
    always_comb begin
        sample_len = cfg[adc_pkg::CFG_LONG_SAMPLE] ? adc_pkg::SAMPLE_LONG : adc_pkg::SAMPLE_SHORT;
        case (cfg[adc_pkg::CFG_MODE_LO +: 2])
            adc_pkg::MODE_12: begin
                bits_len = adc_pkg::BITS_12;
                full_scale = adc_pkg::FULL_12;
                clamped = analog_code;
            end
            adc_pkg::MODE_10: begin
                bits_len = adc_pkg::BITS_10;
                full_scale = adc_pkg::FULL_10;
                clamped = {2'h0, analog_code[11:2]};
            end
            default: begin
                bits_len = adc_pkg::BITS_8;
                full_scale = adc_pkg::FULL_8;
                clamped = {4'h0, analog_code[11:4]};
            end
        endcase
        if (above_high) begin
            clamped = full_scale;
        end else if (below_low) begin
            clamped = adc_pkg::ZERO_CODE;
        end
        cmp_value = {cmp_hi[3:0], cmp_lo};
        diff = {1'b0, sample} - {1'b0, cmp_value};
        if (!sc2_ctl[adc_pkg::SC2_CMP_EN]) begin
            cmp_ok = 1'b1;
        end else if (sc2_ctl[adc_pkg::SC2_CMP_GT]) begin
            cmp_ok = ~diff[12];
        end else begin
            cmp_ok = diff[12];
        end
        stored = sc2_ctl[adc_pkg::SC2_CMP_EN] ? diff[11:0] : sample;
    end

    // Conversion sequencer
    always_comb begin
        hw_edge = trig_sync & ~trig_prev;
        sw_start = wr && paddr == adc_pkg::ADDR_SC1 && !sc2_ctl[adc_pkg::SC2_TRIGGER];
        start = sw_start | (hw_edge & sc2_ctl[adc_pkg::SC2_TRIGGER]);
        finish = 1'b0;
        next_state = state;
        next_count = count;
        next_sample = sample;
        if (start) begin
            next_state = adc_pkg::ST_SAMPLE;
            next_count = 6'h00;
        end else begin
            case (state)
                adc_pkg::ST_IDLE: next_state = adc_pkg::ST_IDLE;
                adc_pkg::ST_SAMPLE: begin
                    if (ck.tick) begin
                        next_count = 6'(count + 6'h01);
                        if (next_count == sample_len) begin
                            next_sample = clamped;
                            next_count = 6'h00;
                            next_state = adc_pkg::ST_CONVERT;
                        end
                    end
                end
                adc_pkg::ST_CONVERT: begin
                    if (ck.tick) begin
                        next_count = 6'(count + 6'h01);
                        if (next_count == bits_len) begin
                            next_state = adc_pkg::ST_TRANSFER;
                        end
                    end
                end
                adc_pkg::ST_TRANSFER: begin
                    if (!lock) begin
                        finish = 1'b1;
                        next_count = 6'h00;
                        next_state = sc1_ctl[adc_pkg::SC1_CONTINUOUS] ? adc_pkg::ST_SAMPLE
                                                                      : adc_pkg::ST_IDLE;
                    end
                end
                default: next_state = adc_pkg::ST_IDLE;
            endcase
        end
        if (deep_stop) begin
            next_state = adc_pkg::ST_IDLE;
            next_count = 6'h00;
            next_sample = adc_pkg::ZERO_CODE;
        end
        sampling = (state == adc_pkg::ST_SAMPLE);
    end

    // Register file next values
    always_comb begin
        next_cfg = cfg;
        next_sc2_ctl = sc2_ctl;
        next_sc1_ctl = sc1_ctl;
        next_cmp_hi = cmp_hi;
        next_cmp_lo = cmp_lo;
        next_pin_lo = pin_lo;
        next_pin_hi = pin_hi;
        next_complete = complete;
        next_lock = lock;
        next_result = result;
        if (wr) begin
            case (paddr)
                adc_pkg::ADDR_CFG: next_cfg = pwdata[7:0];
                adc_pkg::ADDR_SC2: next_sc2_ctl = {1'b0, pwdata[6:4], 4'h0};
                adc_pkg::ADDR_SC1: begin
                    next_sc1_ctl = {1'b0, pwdata[6:0]};
                    next_complete = 1'b0;
                end
                adc_pkg::ADDR_CMP_HI: next_cmp_hi = {4'h0, pwdata[3:0]};
                adc_pkg::ADDR_CMP_LO: next_cmp_lo = pwdata[7:0];
                adc_pkg::ADDR_PIN_LO: next_pin_lo = pwdata[7:0];
                adc_pkg::ADDR_PIN_HI: next_pin_hi = pwdata[7:0];
                default: next_cfg = cfg;
            endcase
        end
        // high read locks, low read frees
        if (rd_acc && paddr == adc_pkg::ADDR_RES_HI) begin
            next_lock = 1'b1;
        end else if (rd_acc && paddr == adc_pkg::ADDR_RES_LO) begin
            next_lock = 1'b0;
        end
        if (finish && cmp_ok) begin
            next_complete = 1'b1;
            next_result = stored;
        end
        if (deep_stop) begin
            next_cfg = adc_pkg::REG_RESET;
            next_sc2_ctl = adc_pkg::REG_RESET;
            next_sc1_ctl = adc_pkg::REG_RESET;
            next_cmp_hi = adc_pkg::REG_RESET;
            next_cmp_lo = adc_pkg::REG_RESET;
            next_pin_lo = adc_pkg::REG_RESET;
            next_pin_hi = adc_pkg::REG_RESET;
            next_complete = 1'b0;
            next_lock = 1'b0;
            next_result = adc_pkg::ZERO_CODE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= adc_pkg::REG_RESET;
            sc2_ctl <= adc_pkg::REG_RESET;
            sc1_ctl <= adc_pkg::REG_RESET;
            cmp_hi <= adc_pkg::REG_RESET;
            cmp_lo <= adc_pkg::REG_RESET;
            pin_lo <= adc_pkg::REG_RESET;
            pin_hi <= adc_pkg::REG_RESET;
            complete <= 1'b0;
            lock <= 1'b0;
            result <= adc_pkg::ZERO_CODE;
            state <= adc_pkg::ST_IDLE;
            count <= 6'h00;
            sample <= adc_pkg::ZERO_CODE;
            prdata <= 32'h00000000;
        end else begin
            cfg <= next_cfg;
            sc2_ctl <= next_sc2_ctl;
            sc1_ctl <= next_sc1_ctl;
            cmp_hi <= next_cmp_hi;
            cmp_lo <= next_cmp_lo;
            pin_lo <= next_pin_lo;
            pin_hi <= next_pin_hi;
            complete <= next_complete;
            lock <= next_lock;
            result <= next_result;
            state <= next_state;
            count <= next_count;
            sample <= next_sample;
            prdata <= next_prdata;
        end
    end

    // Outputs toward the analog side and the system
    always_comb begin
        channel_select = sc1_ctl[adc_pkg::SC1_CHANNEL_LO +: 5];
        low_power = cfg[adc_pkg::CFG_LOW_POWER];
        pin_analog = {pin_hi, pin_lo};
        conv_irq = complete & sc1_ctl[adc_pkg::SC1_IRQ_EN];
    end

    // Checks
    stop_wipes_a: assert property (@(posedge clk) disable iff (rst)
        deep_stop |=> state == adc_pkg::ST_IDLE && cfg == adc_pkg::REG_RESET)
        else $error("deep stop did not reset converter");
    stop_regs_a: assert property (@(posedge clk) disable iff (rst)
        deep_stop |=> !complete && sc1_ctl == adc_pkg::REG_RESET && pin_analog == 16'h0000)
        else $error("registers not at reset after deep stop");
    sw_start_a: assert property (@(posedge clk) disable iff (rst)
        sw_start && !deep_stop |=> state == adc_pkg::ST_SAMPLE && count == 6'h00)
        else $error("software trigger did not start sampling");
    sample_len_a: assert property (@(posedge clk) disable iff (rst)
        state == adc_pkg::ST_SAMPLE |-> count < sample_len)
        else $error("sample phase overran its length");
    active_read_a: assert property (@(posedge clk) disable iff (rst)
        setup && paddr == adc_pkg::ADDR_SC2 |=> prdata[7] == $past(state != adc_pkg::ST_IDLE))
        else $error("active flag read wrong");
    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        setup && paddr == adc_pkg::ADDR_SC2 |=> prdata[3:0] == 4'h0)
        else $error("reserved bits read nonzero");
    lock_hold_a: assert property (@(posedge clk) disable iff (rst)
        lock && state == adc_pkg::ST_TRANSFER && !deep_stop |=> $stable(result))
        else $error("locked result overwritten");
    compare_gate_a: assert property (@(posedge clk) disable iff (rst)
        finish && !cmp_ok && !wr && !deep_stop |=> $stable(result) && complete == $past(complete))
        else $error("failed compare changed result");
    clamp_full_a: assert property (@(posedge clk) disable iff (rst)
        state == adc_pkg::ST_SAMPLE && next_state == adc_pkg::ST_CONVERT && above_high
        |=> sample == full_scale)
        else $error("over-range input not clamped");
    irq_follow_a: assert property (@(posedge clk) disable iff (rst)
        finish && cmp_ok && sc1_ctl[adc_pkg::SC1_IRQ_EN] && !deep_stop |=> conv_irq)
        else $error("completion interrupt missing");
    single_conv_c: cover property (@(posedge clk) disable iff (rst)
        finish && cmp_ok && !sc1_ctl[adc_pkg::SC1_CONTINUOUS]);
    continuous_c: cover property (@(posedge clk) disable iff (rst)
        finish && sc1_ctl[adc_pkg::SC1_CONTINUOUS] ##1 state == adc_pkg::ST_SAMPLE);
    lock_wait_c: cover property (@(posedge clk) disable iff (rst)
        lock && state == adc_pkg::ST_TRANSFER);
endmodule // adc_control

// ==== analog_source_model.sv ====
// Analog sources feeding the converter input
`timescale 1ns/1ps
module analog_source_model (
    // Channel chosen by the converter
    input wire logic [4:0] channel_select,
    // Source level: 0 mid, 1 above high, 2 below low
    input wire logic [1:0] level,
    // Front end
    output logic [11:0] analog_code,
    output logic above_high,
    output logic below_low
);
    // Mid code follows channel so a wrong mux shows
    always_comb begin
        above_high = (level == 2'h1);
        below_low = (level == 2'h2);
        if (above_high) begin
            analog_code = 12'hFFF;
        end else if (below_low) begin
            analog_code = 12'h000;
        end else begin
            analog_code = {7'h40, channel_select};
        end
    end
endmodule // analog_source_model

// ==== tb_top.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic deep_stop = 1'b0;
    logic hw_trigger = 1'b0;
    logic [11:0] analog_code;
    logic above_high;
    logic below_low;
    logic [4:0] channel_select;
    logic sampling;
    logic low_power;
    logic [15:0] pin_analog;
    logic conv_irq;
    logic [1:0] level = 2'h0;
    logic alt_clock = 1'b0;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;

    adc_control i_adc_control (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .deep_stop(deep_stop), .hw_trigger(hw_trigger),
        .alt_clock(alt_clock), .analog_code(analog_code), .above_high(above_high),
        .below_low(below_low), .channel_select(channel_select), .sampling(sampling),
        .low_power(low_power), .pin_analog(pin_analog), .conv_irq(conv_irq));
    analog_source_model i_analog_source_model (.channel_select(channel_select),
        .level(level), .analog_code(analog_code), .above_high(above_high),
        .below_low(below_low));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic final_report();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far above the several hundred cycles used
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // Setup, then access held until pready at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, {24'h0, exp}, r);
    endtask

    task automatic wait_irq(input int n);
        int w;
        w = 0;
        while (conv_irq !== 1'b1 && w < n) begin
            @(posedge clk);
            w++;
        end
    endtask

    // One software-triggered conversion, sample length and clamped result
    task automatic conv(input logic [7:0] cfg, input logic [1:0] lvl, input logic [11:0] code,
        input int samp);
        int n;
        int w;
        n = 0;
        w = 0;
        level <= lvl;
        wr(adc_pkg::ADDR_CFG, cfg);
        wr(adc_pkg::ADDR_SC2, 8'h00);
        wr(adc_pkg::ADDR_SC1, 8'h41);
        while (sampling !== 1'b1 && w < 20) begin
            @(posedge clk);
            w++;
        end
        while (sampling === 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("sample cycles", samp, n);
        chk("channel", 32'h1, {27'h0, channel_select});
        chk("low power", {31'h0, cfg[7]}, {31'h0, low_power});
        wait_irq(60);
        chk("irq", 32'h1, {31'h0, conv_irq});
        rd("sc1 done", adc_pkg::ADDR_SC1, 8'hC1);
        rd("res hi", adc_pkg::ADDR_RES_HI, {4'h0, code[11:8]});
        rd("res lo", adc_pkg::ADDR_RES_LO, code[7:0]);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd("cfg reset", adc_pkg::ADDR_CFG, 8'h00);
        rd("sc1 reset", adc_pkg::ADDR_SC1, 8'h00);
        apb(1'b0, 8'h24, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        wr(adc_pkg::ADDR_RES_LO, 8'h55);
        rd("res lo read only", adc_pkg::ADDR_RES_LO, 8'h00);
        wr(adc_pkg::ADDR_SC2, 8'hFC);
        rd("sc2 reserved", adc_pkg::ADDR_SC2, 8'h70);
        wr(adc_pkg::ADDR_PIN_LO, 8'h02);
        @(posedge clk);
        chk("pin ctl", 32'h2, {16'h0, pin_analog});
    endtask

    // Alternate source: no pin edges, no progress; edges then finish it
    task automatic t_alt();
        wr(adc_pkg::ADDR_CFG, 8'h02);
        wr(adc_pkg::ADDR_SC2, 8'h00);
        wr(adc_pkg::ADDR_SC1, 8'h01);
        repeat (20) @(posedge clk);
        chk("alt hold", 32'h1, {31'h0, sampling});
        repeat (40) @(posedge clk) alt_clock <= ~alt_clock;
        repeat (6) @(posedge clk);
        rd("alt done", adc_pkg::ADDR_SC1, 8'h81);
    endtask

    task automatic t_compare();
        level <= 2'h1;
        wr(adc_pkg::ADDR_CFG, 8'h00);
        wr(adc_pkg::ADDR_CMP_HI, 8'h01);
        wr(adc_pkg::ADDR_CMP_LO, 8'h00);
        rd("cmp hi", adc_pkg::ADDR_CMP_HI, 8'h01);
        wr(adc_pkg::ADDR_SC2, 8'h30);
        wr(adc_pkg::ADDR_SC1, 8'h41);
        repeat (60) @(posedge clk);
        rd("cmp fail sc1", adc_pkg::ADDR_SC1, 8'h41);
        wr(adc_pkg::ADDR_SC2, 8'h20);
        wr(adc_pkg::ADDR_SC1, 8'h41);
        wait_irq(60);
        rd("cmp hi res", adc_pkg::ADDR_RES_HI, 8'h0F);
        rd("cmp lo res", adc_pkg::ADDR_RES_LO, 8'hFF);
    endtask

    task automatic t_hw_cont();
        wr(adc_pkg::ADDR_SC2, 8'h40);
        wr(adc_pkg::ADDR_SC1, 8'h61);
        repeat (6) @(posedge clk);
        chk("no sw start", 32'h0, {31'h0, sampling});
        hw_trigger <= 1'b1;
        wait_irq(80);
        hw_trigger <= 1'b0;
        rd("hw hi", adc_pkg::ADDR_RES_HI, 8'h00);
        // Locked low byte must survive later conversions
        level <= 2'h2;
        repeat (60) @(posedge clk);
        rd("locked lo", adc_pkg::ADDR_RES_LO, 8'hFF);
        repeat (60) @(posedge clk);
        rd("cont lo", adc_pkg::ADDR_RES_LO, 8'h00);
    endtask

    task automatic t_stop();
        level <= 2'h0;
        wr(adc_pkg::ADDR_CFG, 8'h90);
        wr(adc_pkg::ADDR_SC2, 8'h00);
        wr(adc_pkg::ADDR_SC1, 8'h61);
        rd("active", adc_pkg::ADDR_SC2, 8'h80);
        deep_stop <= 1'b1;
        repeat (2) @(posedge clk);
        chk("stop sampling", 32'h0, {31'h0, sampling});
        chk("stop lp", 32'h0, {31'h0, low_power});
        deep_stop <= 1'b0;
        rd("cfg after stop", adc_pkg::ADDR_CFG, 8'h00);
        rd("sc1 after stop", adc_pkg::ADDR_SC1, 8'h00);
        chk("pins after stop", 32'h0, {16'h0, pin_analog});
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        conv(8'h00, 2'h1, adc_pkg::FULL_8, 4);
        conv(8'h98, 2'h2, adc_pkg::ZERO_CODE, 24);
        conv(8'h04, 2'h1, adc_pkg::FULL_12, 4);
        conv(8'h29, 2'h1, adc_pkg::FULL_10, 16);
        t_alt();
        t_compare();
        t_hw_cont();
        t_stop();
        final_report();
    end
endmodule // tb_top
